// *** core/uacb_baud.sv ***
// baud divider: free running 8-bit counter giving sixteen ticks per bit
// assumes clear_i is held while the port is disabled
`timescale 1ns/10ps
module uacb_baud (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic clear_i,
	input wire logic high_speed_i,
	input wire logic [7:0] divisor_i,
	// oversample tick
	output logic tick_o
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [1:0] pre_q;
	logic [1:0] pre_d;
	logic tick_d;

	// low speed adds a divide by four: 64(n+1) versus 16(n+1) clocks per bit
	always_comb begin
		cnt_d = cnt_q + 8'h01;
		pre_d = pre_q;
		tick_d = 1'b0;
		if (clear_i) begin // see RULE10
			cnt_d = 8'h00;
			pre_d = 2'h0;
		end else if (cnt_q == divisor_i) begin // see RULE19
			cnt_d = 8'h00;
			pre_d = pre_q + 2'h1;
			tick_d = high_speed_i || (pre_q == uacb_pkg::LOW_PRESCALE_LAST); // see RULE18
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 8'h00;
			pre_q <= 2'h0;
			tick_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			pre_q <= pre_d;
			tick_o <= tick_d;
		end
	end
endmodule // uacb_baud

// *** core/uacb_serial.sv ***
// serial port control, frame engines and wishbone register slave
// assumes pin muxing to general i/o outside, driven by the ownership outputs
// Summary of operation
// RULE1: parity error flag set on bad parity, cleared by status read then data access.
// RULE2: nine-bit mode sends tx_ninth_bit as ninth data bit.
// RULE3: nine-bit mode stores ninth received bit into rx_ninth_bit.
// RULE4: break drives output low at least 13 bits after buffer drains, until cleared.
// RULE5: stop_count_sel one gives two stop bits, zero gives one.
// RULE6: parity_type_sel one gives odd parity, zero gives even.
// RULE7: parity generated and checked only with parity_enable set.
// RULE8: data_length_sel one gives nine data bits, zero gives eight.
// RULE9: pins are general i/o while disabled, else follow tx and rx enables.
// RULE10: disabling empties receive buffer and resets the baud counter.
// RULE11: disabling clears enables, break, receive flags; sets idle and empty flags.
// RULE12: disabling aborts transfers; re-enabling keeps previous configuration.
// RULE13: tx_empty_int_en passes tx_empty_flag to the interrupt request.
// RULE14: tx_idle_int_en passes tx_idle_flag to the interrupt request.
// RULE15: rx_int_en passes overrun or rx_full_flag to the interrupt request.
// RULE16: in power-down, falling receive edge wakes device when rx_wake_en set.
// RULE17: address detect keeps only words whose top bit is one.
// RULE18: bit rate is clock over 64(n+1), or 16(n+1) in high speed.
// RULE19: free running 8-bit divider, n from 0 to 255, times both directions.
// RULE20: rx_enable low aborts reception, resets buffer, releases receive pin.
// RULE21: tx_enable low aborts transmission, resets buffer, releases transmit pin.
// RULE22: frame is start, eight or nine data bits lsb first, parity, stop_count_sel.
// RULE23: transmit pin stays high whenever nothing is sent.
// RULE24: parity follows last data bit; received bits sampled mid period.
`timescale 1ns/10ps
module uacb_serial (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// serial pins
	input wire logic rx_i,
	output logic tx_o,
	output logic tx_oe_o,
	output logic rx_owned_o,
	// power and interrupt
	input wire logic power_down_i,
	output logic wake_o,
	output logic irq_o
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] c1_q, c1_d, c2_q, c2_d, div_q, div_d, rxd_q, rxd_d;
	logic rxf_q, rxf_d, ovr_q, ovr_d, fe_q, fe_d, pe_q, pe_d, nf_q, nf_d, arm_q, arm_d;
	logic irq_d, wake_d, txoe_d, rxown_d, ack_d;
	logic [31:0] rdat_d;
	logic [2:0] sync_q;
	logic lvl_q, lvl_d, fall;
	logic uart_en, tx_act, rx_act, tick, req, commit, data_acc, data_wr, data_rd, clr_seq;
	logic tx_empty, tx_idle;
	logic [3:0] nd, last;
	uacb_pkg::uacb_tx_state_t ts_q, ts_d;
	logic [3:0] tt_q, tt_d, tl_q, tl_d;
	logic [12:0] tf_q, tf_d;
	logic [8:0] hold_q, hold_d;
	logic hf_q, hf_d, tx_d, tpar;
	uacb_pkg::uacb_rx_state_t rs_q, rs_d;
	logic [3:0] rt_q, rt_d, ri_q, ri_d;
	logic [9:0] rsh_q, rsh_d;
	logic [1:0] vote_q, vote_d;
	logic rn_q, rn_d, maj, noisy;
	logic rx_done, rx_parity_error_flag, rx_framing_error_flag, rx_noise, rx_keep, rx_top;
	logic [8:0] rx_word;

	assign uart_en = c1_q[uacb_pkg::C1_UEN];
	assign tx_act = uart_en && c2_q[uacb_pkg::C2_TX_ENABLE]; // see RULE21
	assign rx_act = uart_en && c2_q[uacb_pkg::C2_RX_ENABLE]; // see RULE20
	assign req = wb_cyc_i && wb_stb_i;
	// writes and read side effects land on the edge where the master sees ack
	assign commit = req && wb_ack_o;
	assign data_acc = commit && (wb_adr_i == uacb_pkg::ADDR_DATA);
	assign data_wr = data_acc && wb_we_i && wb_sel_i[0];
	assign data_rd = data_acc && !wb_we_i;
	assign clr_seq = data_acc && arm_q; // see RULE1
	assign nd = c1_q[uacb_pkg::C1_DLEN] ? uacb_pkg::DATA_BITS_9 : uacb_pkg::DATA_BITS_8; // see RULE8
	assign last = nd + {3'b000, c1_q[uacb_pkg::C1_PEN]} + 4'h1;
	assign tx_empty = !hf_q;
	assign tx_idle = !hf_q && (ts_q == uacb_pkg::TX_IDLE) && !c1_q[uacb_pkg::C1_BRK];

	// ----------------------------------------
	// baud divider
	// ----------------------------------------
	uacb_baud u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(!uart_en), // see RULE10
		.high_speed_i(c2_q[uacb_pkg::C2_HS]),
		.divisor_i(div_q),
		.tick_o(tick)
	);

	// ----------------------------------------
	// receive pin synchroniser
	// ----------------------------------------
	// a level counts only once the two later stages agree
	always_comb begin
		lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
		fall = lvl_q && !lvl_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_q <= 3'h7;
			lvl_q <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], rx_i};
			lvl_q <= lvl_d;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	always_comb begin
		ts_d = ts_q;
		tt_d = tt_q;
		tl_d = tl_q;
		tf_d = tf_q;
		hold_d = hold_q;
		hf_d = hf_q;
		tpar = ^hold_q[7:0] ^ (c1_q[uacb_pkg::C1_DLEN] & hold_q[8]) ^ c1_q[uacb_pkg::C1_PTYPE]; // see RULE6
		case (ts_q)
			uacb_pkg::TX_IDLE: begin
				if (hf_q) begin // see RULE22
					tf_d = 13'h1fff;
					tf_d[0] = 1'b0;
					tf_d[8:1] = hold_q[7:0];
					if (c1_q[uacb_pkg::C1_DLEN]) begin
						tf_d[9] = hold_q[8]; // see RULE2
					end
					if (c1_q[uacb_pkg::C1_PEN]) begin
						tf_d[nd + 4'h1] = tpar; // see RULE7 RULE24
					end
					// start, data, parity and every stop bit each get a full bit time
					tl_d = last + {3'b000, c1_q[uacb_pkg::C1_STOP_COUNT_SEL]} + 4'h1; // see RULE5
					tt_d = 4'h0;
					hf_d = 1'b0;
					ts_d = uacb_pkg::TX_SEND;
				end else if (c1_q[uacb_pkg::C1_BRK]) begin // see RULE4
					tl_d = uacb_pkg::BREAK_BITS;
					tt_d = 4'h0;
					ts_d = uacb_pkg::TX_BREAK;
				end
			end
			uacb_pkg::TX_SEND: begin
				if (tick) begin
					tt_d = tt_q + 4'h1;
					if (tt_q == uacb_pkg::TICK_LAST) begin
						tf_d = {1'b1, tf_q[12:1]};
						tl_d = tl_q - 4'h1;
						if (tl_q == 4'h1) begin
							ts_d = uacb_pkg::TX_IDLE;
						end
					end
				end
			end
			uacb_pkg::TX_BREAK: begin
				if (tick) begin
					tt_d = tt_q + 4'h1;
					if (tt_q == uacb_pkg::TICK_LAST && tl_q != 4'h0) begin
						tl_d = tl_q - 4'h1;
					end
				end
				if (tl_q == 4'h0 && !c1_q[uacb_pkg::C1_BRK]) begin // see RULE4
					ts_d = uacb_pkg::TX_IDLE;
				end
			end
			default: begin
				ts_d = uacb_pkg::TX_IDLE;
			end
		endcase
		// a second write before the shifter takes the first one overwrites it
		if (data_wr && tx_act) begin
			hold_d = {c1_q[uacb_pkg::C1_TX9], wb_dat_i[7:0]};
			hf_d = 1'b1;
		end
		if (!tx_act) begin // see RULE12 RULE21
			ts_d = uacb_pkg::TX_IDLE;
			hf_d = 1'b0;
		end
		case (ts_d)
			uacb_pkg::TX_SEND: tx_d = tf_d[0];
			uacb_pkg::TX_BREAK: tx_d = 1'b0;
			default: tx_d = 1'b1; // see RULE23
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ts_q <= uacb_pkg::TX_IDLE;
			tt_q <= 4'h0;
			tl_q <= 4'h0;
			tf_q <= 13'h1fff;
			hold_q <= 9'h000;
			hf_q <= 1'b0;
			tx_o <= 1'b1;
		end else begin
			ts_q <= ts_d;
			tt_q <= tt_d;
			tl_q <= tl_d;
			tf_q <= tf_d;
			hold_q <= hold_d;
			hf_q <= hf_d;
			tx_o <= tx_d;
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	// three votes around the bit centre; any disagreement after the start bit marks noise
	always_comb begin
		rs_d = rs_q;
		rt_d = rt_q;
		ri_d = ri_q;
		rsh_d = rsh_q;
		vote_d = vote_q;
		rn_d = rn_q;
		rx_done = 1'b0;
		maj = (vote_q[1] & vote_q[0]) | (vote_q[1] & lvl_q) | (vote_q[0] & lvl_q);
		noisy = !((vote_q[1] == vote_q[0]) && (vote_q[0] == lvl_q));
		rx_word = {c1_q[uacb_pkg::C1_DLEN] & rsh_q[8], rsh_q[7:0]};
		rx_top = c1_q[uacb_pkg::C1_DLEN] ? rsh_q[8] : rsh_q[7]; // see RULE17
		rx_parity_error_flag = c1_q[uacb_pkg::C1_PEN]
			&& (rsh_q[nd] != (^rx_word ^ c1_q[uacb_pkg::C1_PTYPE])); // see RULE1 RULE6 RULE7
		rx_framing_error_flag = !maj;
		rx_noise = rn_q || noisy;
		rx_keep = !c2_q[uacb_pkg::C2_ADDRESS_DETECT_EN] || rx_top; // see RULE17
		case (rs_q)
			uacb_pkg::RX_IDLE: begin
				if (rx_act && fall) begin
					rs_d = uacb_pkg::RX_BUSY;
					rt_d = 4'h0;
					ri_d = 4'h0;
					rn_d = 1'b0;
				end
			end
			uacb_pkg::RX_BUSY: begin
				if (tick) begin
					rt_d = rt_q + 4'h1;
					if (rt_q == uacb_pkg::VOTE_A || rt_q == uacb_pkg::VOTE_B) begin
						vote_d = {vote_q[0], lvl_q};
					end
					if (rt_q == uacb_pkg::VOTE_C) begin // see RULE24
						ri_d = ri_q + 4'h1;
						if (ri_q == 4'h0) begin
							if (maj) begin
								rs_d = uacb_pkg::RX_IDLE;
							end
						end else if (ri_q == last) begin // see RULE22
							rx_done = 1'b1;
							rs_d = uacb_pkg::RX_IDLE;
						end else begin
							rsh_d[ri_q - 4'h1] = maj;
							rn_d = rn_q || noisy;
						end
					end
				end
			end
			default: begin
				rs_d = uacb_pkg::RX_IDLE;
			end
		endcase
		if (!rx_act) begin // see RULE12 RULE20
			rs_d = uacb_pkg::RX_IDLE;
			rx_done = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rs_q <= uacb_pkg::RX_IDLE;
			rt_q <= 4'h0;
			ri_q <= 4'h0;
			rsh_q <= 10'h000;
			vote_q <= 2'h0;
			rn_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			rt_q <= rt_d;
			ri_q <= ri_d;
			rsh_q <= rsh_d;
			vote_q <= vote_d;
			rn_q <= rn_d;
		end
	end

	// ----------------------------------------
	// registers, flags and bus answer
	// ----------------------------------------
	always_comb begin
		c1_d = c1_q;
		c2_d = c2_q;
		div_d = div_q;
		rxd_d = rxd_q;
		rxf_d = rxf_q;
		ovr_d = ovr_q;
		fe_d = fe_q;
		pe_d = pe_q;
		nf_d = nf_q;
		arm_d = arm_q;
		ack_d = req && !wb_ack_o;
		rdat_d = 32'h0000_0000;
		if (commit && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				uacb_pkg::ADDR_CTRL1: begin
					c1_d = wb_dat_i[7:0];
					c1_d[uacb_pkg::C1_RX9] = c1_q[uacb_pkg::C1_RX9];
				end
				uacb_pkg::ADDR_CTRL2: c2_d = wb_dat_i[7:0];
				uacb_pkg::ADDR_BAUD: div_d = wb_dat_i[7:0]; // see RULE19
				default: c1_d = c1_q;
			endcase
		end
		if (commit && !wb_we_i && wb_adr_i == uacb_pkg::ADDR_STATUS) begin
			arm_d = 1'b1;
		end else if (data_acc) begin
			arm_d = 1'b0;
		end
		if (clr_seq) begin // see RULE1
			ovr_d = 1'b0;
			fe_d = 1'b0;
			pe_d = 1'b0;
			nf_d = 1'b0;
			if (data_rd) begin
				rxf_d = 1'b0;
			end
		end
		// a new word in the same cycle as the clear wins over that clear
		if (rx_done) begin
			if ((rxf_q || ovr_q) && !clr_seq) begin
				ovr_d = 1'b1;
			end else if (rx_keep) begin // see RULE17
				rxf_d = 1'b1;
				rxd_d = rx_word[7:0];
				c1_d[uacb_pkg::C1_RX9] = rx_word[8]; // see RULE3
				fe_d = rx_framing_error_flag;
				pe_d = rx_parity_error_flag; // see RULE1
				nf_d = rx_noise;
			end
		end
		if (!rx_act) begin // see RULE10 RULE11 RULE20
			rxf_d = 1'b0;
			ovr_d = 1'b0;
			fe_d = 1'b0;
			pe_d = 1'b0;
			nf_d = 1'b0;
		end
		// enables and break stay cleared while the port is off; other settings survive
		if (!c1_d[uacb_pkg::C1_UEN]) begin // see RULE11 RULE12
			c1_d[uacb_pkg::C1_BRK] = 1'b0;
			c2_d[uacb_pkg::C2_TX_ENABLE] = 1'b0;
			c2_d[uacb_pkg::C2_RX_ENABLE] = 1'b0;
		end
		if (req && !wb_ack_o && !wb_we_i) begin
			case (wb_adr_i)
				uacb_pkg::ADDR_CTRL1: rdat_d[7:0] = c1_q;
				uacb_pkg::ADDR_CTRL2: rdat_d[7:0] = c2_q;
				uacb_pkg::ADDR_BAUD: rdat_d[7:0] = div_q;
				uacb_pkg::ADDR_DATA: rdat_d[7:0] = rxd_q;
				uacb_pkg::ADDR_STATUS: begin
					rdat_d[uacb_pkg::ST_TXE] = tx_empty;
					rdat_d[uacb_pkg::ST_TX_IDLE_FLAG] = tx_idle;
					rdat_d[uacb_pkg::ST_RXF] = rxf_q;
					rdat_d[uacb_pkg::ST_RX_IDLE_FLAG] = (rs_q == uacb_pkg::RX_IDLE);
					rdat_d[uacb_pkg::ST_OVR] = ovr_q;
					rdat_d[uacb_pkg::ST_FE] = fe_q;
					rdat_d[uacb_pkg::ST_NF] = nf_q;
					rdat_d[uacb_pkg::ST_PE] = pe_q;
				end
				default: rdat_d = 32'h0000_0000;
			endcase
		end
		irq_d = (c2_q[uacb_pkg::C2_TX_EMPTY_INT_EN] && tx_empty) // see RULE13
			|| (c2_q[uacb_pkg::C2_TIIE] && tx_idle) // see RULE14
			|| (c2_q[uacb_pkg::C2_RIE] && (rxf_q || ovr_q)); // see RULE15
		wake_d = power_down_i && c2_q[uacb_pkg::C2_WAKE] && fall; // see RULE16
		txoe_d = tx_act; // see RULE9 RULE21
		rxown_d = rx_act; // see RULE9 RULE20
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c1_q <= uacb_pkg::CTRL1_RST;
			c2_q <= uacb_pkg::CTRL2_RST;
			div_q <= uacb_pkg::BAUD_RST;
			rxd_q <= 8'h00;
			rxf_q <= 1'b0;
			ovr_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
			nf_q <= 1'b0;
			arm_q <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq_o <= 1'b0;
			wake_o <= 1'b0;
			tx_oe_o <= 1'b0;
			rx_owned_o <= 1'b0;
		end else begin
			c1_q <= c1_d;
			c2_q <= c2_d;
			div_q <= div_d;
			rxd_q <= rxd_d;
			rxf_q <= rxf_d;
			ovr_q <= ovr_d;
			fe_q <= fe_d;
			pe_q <= pe_d;
			nf_q <= nf_d;
			arm_q <= arm_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= rdat_d;
			irq_o <= irq_d;
			wake_o <= wake_d;
			tx_oe_o <= txoe_d;
			rx_owned_o <= rxown_d;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_PARITY_FLAG: assert property (rx_done && rx_parity_error_flag && rx_keep && !rxf_q && !ovr_q |=> pe_q) // see RULE1
		else $error("parity error not flagged");
	AST_BREAK_LOW: assert property (ts_q == uacb_pkg::TX_BREAK |-> !tx_o) // see RULE4
		else $error("break not driving low");
	AST_BREAK_HOLD: assert property (ts_q == uacb_pkg::TX_BREAK && tl_q != 4'h0 && tx_act
		|=> ts_q == uacb_pkg::TX_BREAK || !$past(tx_act)) // see RULE4
		else $error("break ended early");
	AST_IDLE_HIGH: assert property (ts_q == uacb_pkg::TX_IDLE |-> tx_o) // see RULE23
		else $error("idle line not high");
	AST_DISABLED: assert property (!uart_en && !c1_d[uacb_pkg::C1_UEN] |=> tx_empty && tx_idle && rs_q == uacb_pkg::RX_IDLE
		&& !rxf_q && !pe_q && !ovr_q) // see RULE11
		else $error("disable did not reset state");
	AST_IRQ_EMPTY: assert property (tx_empty && c2_q[uacb_pkg::C2_TX_EMPTY_INT_EN] |=> irq_o) // see RULE13
		else $error("empty interrupt missing");
	AST_IRQ_RX: assert property (rxf_q && c2_q[uacb_pkg::C2_RIE] |=> irq_o) // see RULE15
		else $error("receive interrupt missing");
	AST_TX_OWN: assert property (!tx_act |=> !tx_oe_o) // see RULE21
		else $error("transmit pin still owned");
	AST_WAKE: assert property (wake_o |-> $past(power_down_i) && $past(c2_q[uacb_pkg::C2_WAKE])) // see RULE16
		else $error("unexpected wake");
	AST_ADDR_DROP: assert property (rx_done && !rx_keep && !rxf_q |=> !rxf_q) // see RULE17
		else $error("data word kept in address mode");

	COV_BREAK: cover property (ts_q == uacb_pkg::TX_BREAK && tl_q == 4'h0);
	COV_PARITY_ERROR_FLAG: cover property ($rose(pe_q));
	COV_ADDR: cover property (rx_done && c2_q[uacb_pkg::C2_ADDRESS_DETECT_EN] && rx_keep);
	COV_OVR: cover property ($rose(ovr_q));
endmodule // uacb_serial

// *** shared/uacb_pkg.sv ***
// constants shared by the serial port control block and its baud divider
// assumes a 32-bit classic wishbone master with byte addresses
package uacb_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_BAUD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_DATA = 8'h10;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	// ----------------------------------------
	// uart_control_one fields
	// ----------------------------------------
	localparam int C1_TX9 = 0;
	localparam int C1_RX9 = 1;
	localparam int C1_BRK = 2;
	localparam int C1_STOP_COUNT_SEL = 3;
	localparam int C1_PTYPE = 4;
	localparam int C1_PEN = 5;
	localparam int C1_DLEN = 6;
	localparam int C1_UEN = 7;
	// ----------------------------------------
	// uart_control_two fields
	// ----------------------------------------
	localparam int C2_TX_EMPTY_INT_EN = 0;
	localparam int C2_TIIE = 1;
	localparam int C2_RIE = 2;
	localparam int C2_WAKE = 3;
	localparam int C2_ADDRESS_DETECT_EN = 4;
	localparam int C2_HS = 5;
	localparam int C2_RX_ENABLE = 6;
	localparam int C2_TX_ENABLE = 7;
	// ----------------------------------------
	// serial_status_reg fields
	// ----------------------------------------
	localparam int ST_TXE = 0;
	localparam int ST_TX_IDLE_FLAG = 1;
	localparam int ST_RXF = 2;
	localparam int ST_RX_IDLE_FLAG = 3;
	localparam int ST_OVR = 4;
	localparam int ST_FE = 5;
	localparam int ST_NF = 6;
	localparam int ST_PE = 7;
	// ----------------------------------------
	// bit timing, sixteen ticks per bit
	// ----------------------------------------
	localparam logic [1:0] LOW_PRESCALE_LAST = 2'h3;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] VOTE_A = 4'h7;
	localparam logic [3:0] VOTE_B = 4'h8;
	localparam logic [3:0] VOTE_C = 4'h9;
	localparam logic [3:0] BREAK_BITS = 4'hd;
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	// ----------------------------------------
	// state machines
	// ----------------------------------------
	typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_BREAK = 3'b100} uacb_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} uacb_rx_state_t;
endpackage

// *** verification/tb_top.sv ***
// self-checking bench for the serial port control block
// assumes a single 100 MHz clock and the peer model on the serial pins
`timescale 1ns/10ps
module tb_top;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0000_0000;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic rx;
	logic tx;
	logic tx_oe;
	logic rx_owned;
	logic power_down = 1'b0;
	logic wake;
	logic irq;
	int err_count = 0;
	int checks = 0;
	always #5 clk_i = ~clk_i;
	uacb_serial uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.rx_i(rx), .tx_o(tx), .tx_oe_o(tx_oe), .rx_owned_o(rx_owned), .power_down_i(power_down),
		.wake_o(wake), .irq_o(irq));
	uacb_peer peer (.clk_i(clk_i), .line_i(tx), .line_o(rx));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// holds the request until ack is sampled high, then releases
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		r = wb_rdat[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin
			err_count++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		wb(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		wb(1'b0, a, 8'h00, r);
	endtask
	// divisor goes first, then port enable, then the direction enables
	task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] n);
		wr(uacb_pkg::ADDR_BAUD, n);
		wr(uacb_pkg::ADDR_CTRL1, c1 | 8'h80);
		wr(uacb_pkg::ADDR_CTRL2, c2);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] r;
		rd(uacb_pkg::ADDR_CTRL1, r);
		chk("ctrl1 reset", 16'(r), 16'(uacb_pkg::CTRL1_RST));
		rd(uacb_pkg::ADDR_CTRL2, r);
		chk("ctrl2 reset", 16'(r), 16'(uacb_pkg::CTRL2_RST));
		rd(uacb_pkg::ADDR_BAUD, r);
		chk("baud reset", 16'(r), 16'(uacb_pkg::BAUD_RST));
		rd(8'h14, r);
		chk("unmapped", 16'(r), 16'h0000);
		chk("idle line", 16'(tx), 16'h0001);
	endtask
	// two frames back to back: second waits in the holding register
	task automatic t_tx(input logic [7:0] c1, input logic [7:0] d, input logic hs, input logic [7:0] n);
		int nd;
		int bt;
		int per;
		logic [10:0] e;
		logic [10:0] w;
		nd = c1[6] ? 9 : 8;
		bt = (hs ? 16 : 64) * (n + 1);
		e = {3'h0, d};
		e[8] = c1[6] & c1[0];
		if (c1[5]) begin
			e[nd] = (^e[8:0]) ^ c1[4];
		end
		cfg(c1, {2'b11, hs, 5'h00}, n);
		fork
			peer.grab(nd + c1[5], bt, w, per);
			begin
				wr(uacb_pkg::ADDR_DATA, d);
				wr(uacb_pkg::ADDR_DATA, d);
			end
		join
		if (per >= 9000) begin
			err_count++;
			finish_test();
		end
		chk("tx word", 16'(w), 16'(e));
		chk("frame bits", 16'((per + bt / 2) / bt), 16'(2 + nd + c1[5] + c1[3]));
		repeat (14 * bt) @(posedge clk_i);
	endtask
	task automatic t_irq();
		logic [7:0] en [3] = '{8'he1, 8'he2, 8'he0};
		for (int i = 0; i < 3; i++) begin
			wr(uacb_pkg::ADDR_CTRL2, en[i]);
			repeat (3) @(posedge clk_i);
			chk("irq tx", 16'(irq), 16'(i < 2));
		end
	endtask
	task automatic t_break();
		int n;
		wr(uacb_pkg::ADDR_CTRL1, 8'h84);
		n = 0;
		repeat (20) @(posedge clk_i);
		for (int i = 0; i < 13 * 16; i++) begin
			@(posedge clk_i);
			n += (tx === 1'b0);
		end
		chk("break low", 16'(n), 16'(13 * 16));
		wr(uacb_pkg::ADDR_CTRL1, 8'h80);
		n = 0;
		while (tx !== 1'b1 && n < 64) begin
			@(posedge clk_i);
			n++;
		end
		if (tx !== 1'b1) begin
			err_count++;
			finish_test();
		end
		chk("break end", 16'(tx), 16'h0001);
	endtask
	task automatic t_rx(input logic [7:0] c1, input logic [7:0] c2, input logic [10:0] w, input int nb,
		input logic full, input logic pe, input logic [7:0] d, input logic b9);
		logic [7:0] r;
		cfg(c1, c2, 8'h00);
		peer.send(w, nb, 16);
		repeat (4) @(posedge clk_i);
		chk("irq rx", 16'(irq), 16'(full));
		rd(uacb_pkg::ADDR_STATUS, r);
		chk("rx full", 16'(r[2]), 16'(full));
		chk("parity error", 16'(r[7]), 16'(pe));
		if (full) begin
			rd(uacb_pkg::ADDR_DATA, r);
			chk("rx data", 16'(r), 16'(d));
			rd(uacb_pkg::ADDR_CTRL1, r);
			chk("ninth bit", 16'(r[1]), 16'(b9));
			rd(uacb_pkg::ADDR_STATUS, r);
			chk("flags cleared", 16'(r & 8'h84), 16'h0000);
		end
	endtask
	task automatic t_wake(input logic en, input int exp);
		int n;
		wr(uacb_pkg::ADDR_CTRL2, {4'he, en, 3'h0});
		power_down <= 1'b1;
		n = 0;
		fork
			peer.send(11'h000, 8, 16);
			repeat (40) begin
				@(posedge clk_i);
				n += (wake === 1'b1);
			end
		join
		power_down <= 1'b0;
		chk("wake pulses", 16'(n), 16'(exp));
	endtask
	// leaves the receive buffer full beforehand so the flush shows
	task automatic t_disable();
		logic [7:0] r;
		rd(uacb_pkg::ADDR_STATUS, r);
		chk("status before off", 16'(r), 16'h001f);
		wr(uacb_pkg::ADDR_BAUD, 8'h05);
		wr(uacb_pkg::ADDR_CTRL1, 8'h08);
		repeat (2) @(posedge clk_i);
		chk("pins off", 16'({tx_oe, rx_owned}), 16'h0000);
		rd(uacb_pkg::ADDR_CTRL1, r);
		chk("ctrl1 off", 16'(r), 16'h0008);
		rd(uacb_pkg::ADDR_CTRL2, r);
		chk("ctrl2 off", 16'(r), 16'h0020);
		rd(uacb_pkg::ADDR_BAUD, r);
		chk("baud kept", 16'(r), 16'h0005);
		rd(uacb_pkg::ADDR_STATUS, r);
		chk("status off", 16'(r), 16'h000b);
		cfg(8'h00, 8'h60, 8'h00);
		repeat (2) @(posedge clk_i);
		chk("rx only pins", 16'({tx_oe, rx_owned}), 16'h0001);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_tx(8'h00, 8'h96, 1'b0, 8'h01);
		t_tx(8'h00, 8'ha5, 1'b1, 8'h00);
		t_tx(8'h08, 8'ha5, 1'b1, 8'h00);
		t_tx(8'h20, 8'ha5, 1'b1, 8'h00);
		t_tx(8'h30, 8'ha5, 1'b1, 8'h00);
		t_tx(8'h41, 8'h3c, 1'b1, 8'h00);
		t_tx(8'h79, 8'h5a, 1'b1, 8'h00);
		t_irq();
		t_break();
		t_rx(8'he0, 8'he4, 11'h33c, 10, 1'b1, 1'b0, 8'h3c, 1'b1);
		t_rx(8'he0, 8'he4, 11'h13c, 10, 1'b1, 1'b1, 8'h3c, 1'b1);
		t_rx(8'hb0, 8'he4, 11'h001, 9, 1'b1, 1'b0, 8'h01, 1'b0);
		t_rx(8'h80, 8'hf4, 11'h012, 8, 1'b0, 1'b0, 8'h00, 1'b0);
		t_rx(8'h80, 8'hf4, 11'h092, 8, 1'b1, 1'b0, 8'h92, 1'b0);
		t_wake(1'b1, 1);
		t_wake(1'b0, 0);
		t_disable();
		t_tx(8'h00, 8'hc3, 1'b1, 8'h00);
		finish_test();
	end
endmodule // tb_top

// *** verification/uacb_peer.sv ***
// far-end serial device model on the transmit and receive lines
// assumes the bench calls one task at a time; bit time given in clocks
`timescale 1ns/10ps
module uacb_peer (
	// clock
	input wire logic clk_i,
	// serial lines
	input wire logic line_i,
	output logic line_o
);
	// ----------------------------------------
	// frame tasks
	// ----------------------------------------
	initial line_o = 1'b1;
	// start, nb bits lsb first, one stop; line idles high after
	task automatic send(input logic [10:0] w, input int nb, input int bt);
		logic [12:0] f;
		f = {2'b11, w, 1'b0};
		f[nb+1] = 1'b1;
		for (int i = 0; i < nb + 2; i++) begin
			line_o <= f[i];
			repeat (bt) @(posedge clk_i);
		end
	endtask
	// samples mid bit; per is start to next start in clocks
	task automatic grab(input int nb, input int bt, output logic [10:0] w, output int per);
		int n;
		w = '0;
		n = 0;
		while (line_i !== 1'b0 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (bt / 2) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			repeat (bt) @(posedge clk_i);
			w[i] = line_i;
		end
		n = bt / 2 + nb * bt;
		while (line_i !== 1'b1 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		while (line_i !== 1'b0 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		per = n;
	endtask
endmodule // uacb_peer
